//--- src/lsd_map.svh
// Offsets, field positions, reset values and timing counts for the
// loop stall diagnosis event. Included by the top module and the testbench.
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH
// Register byte offsets on the AXI4-Lite slave.
`define LSD_OFF_CTRL 8'h00
`define LSD_OFF_MAIN 8'h04
`define LSD_OFF_SUB 8'h08
`define LSD_OFF_ONDLY 8'h0C
`define LSD_OFF_OFFDLY 8'h10
`define LSD_OFF_STAT 8'h14
`define LSD_OFF_IRQSTS 8'h18
`define LSD_OFF_IRQMSK 8'h1C
// Control field positions.
`define LSD_CTRL_TYPE_MSB 4
`define LSD_CTRL_REV_BIT 8
// Operation type code that selects this diagnosis.
`define LSD_TYPE_STALL 5'h16
// Manipulated output limits in tenths of a percent (100% and 0%).
`define LSD_MV_HI 16'h03E8
`define LSD_MV_LO 16'h0000
// Reset values of the settings.
`define LSD_RST_MAIN 16'h000A
`define LSD_RST_SUB 16'h0005
`define LSD_RST_ONDLY 16'h0064
`define LSD_RST_OFFDLY 16'h0032
// Interrupt status bits: event raised, event dropped.
`define LSD_IRQ_RISE 0
`define LSD_IRQ_FALL 1
// Control sampling period and system clock period.
`define LSD_SAMPLE_NS 100000000
`define LSD_CLK_NS 25
`define LSD_SAMPLE_CYC (`LSD_SAMPLE_NS / `LSD_CLK_NS)
// AXI responses.
`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_SLVERR 2'h2
`endif

//--- src/lsd_pkg.sv
// Types shared by the loop stall diagnosis event block.
// Assumes the map header sits in the include path.
package lsd_pkg;
  // One sample of the loop: signed process value and setpoint,
  // output in tenths of a percent.
  typedef struct packed {
    logic signed [15:0] process_value;
    logic signed [15:0] setpoint_value;
    logic [15:0] manipulated_output;
  } loop_sample_s;

  // Where the manipulated output sits relative to its limits.
  typedef enum logic [2:0] {
    LIM_NONE = 3'b001,
    LIM_HI = 3'b010,
    LIM_LO = 3'b100
  } limit_e;

  // Whole state of the block.
  typedef struct packed {
    logic [21:0] div_cnt;
    logic tick;
    logic [4:0] op_type;
    logic reverse;
    logic [15:0] main_set;
    logic [15:0] sub_set;
    logic [15:0] on_dly;
    logic [15:0] off_dly;
    logic [15:0] boot_cnt;
    logic boot_done;
    limit_e lim;
    logic signed [15:0] ref_pv;
    logic [15:0] tmr;
    logic event_on;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lsd_state_s;
endpackage

//--- src/loop_stall_diag.sv
// Loop stall diagnosis event with an AXI4-Lite register slave.
// Assumes loop samples come from logic on the same clock and are steady
// around each sampling tick; one clock, asynchronous active-low reset.
//
// Behaviour
// R01: Diagnosis active only for operation type 22.
// R02: Measure change from reference captured at limit.
// R03: Diagnosis time elapses before judging the change.
// R04: Heat: small rise at high, fall at low.
// R05: Cool: small fall at high, rise at low.
// R06: Small deviation forces event off.
// R07: Event held off for off-delay after reset.
// R08: Timer runs only with limit and hold satisfied.
// R09: Evaluate per sampling tick; restart leaving limit.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lsd_map.svh"

module loop_stall_diag #(
  parameter int SAMPLE_CYCLES = `LSD_SAMPLE_CYC
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Loop samples.
  input wire lsd_pkg::loop_sample_s i_sample,
  // AXI4-Lite write channels.
  input wire logic i_s_axi_awvalid,
  input wire logic [7:0] i_s_axi_awaddr,
  output logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_wready,
  output logic o_s_axi_bvalid,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic i_s_axi_arvalid,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_arready,
  output logic o_s_axi_rvalid,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_s_axi_rready,
  // Event and interrupt.
  output logic o_event,
  output logic o_irq
);

  // Applies byte enables of a write to a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // True when a 16-bit counter has reached a setting.
  function automatic logic reached(input logic [15:0] cnt,
                                   input logic [15:0] lim);
    return cnt >= lim;
  endfunction

  // Saturating increment so that long waits never wrap.
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  lsd_pkg::lsd_state_s st; // Registered state.
  lsd_pkg::lsd_state_s next_st; // Next value of the state.

  // Loop arithmetic, widened so that differences never overflow.
  logic signed [17:0] dev; // Process value minus setpoint.
  logic [17:0] dev_abs; // Magnitude of the deviation.
  logic dev_ok; // Deviation large enough to allow the event.
  logic at_hi; // Output at its upper limit.
  logic at_lo; // Output at its lower limit.
  logic signed [17:0] rise; // Rise of process value since reference.
  logic small_up; // Rise smaller than the main setting.
  logic small_dn; // Fall smaller than the main setting.
  logic stall; // Stall condition for the present polarity.
  logic [31:0] rd_word; // Read data for the present read address.
  logic rd_hit; // Read address is mapped.
  logic wr_hit; // Write address is mapped.

  // Deviation, limits and change since the reference.
  always_comb begin
    dev = 18'(i_sample.process_value) - 18'(i_sample.setpoint_value);
    dev_abs = dev[17] ? 18'(-dev) : 18'(dev);
    dev_ok = dev_abs >= {2'h0, st.sub_set};
    at_hi = i_sample.manipulated_output >= `LSD_MV_HI;
    at_lo = i_sample.manipulated_output == `LSD_MV_LO;
    // A fresh reference is the present sample, so the change is zero.
    if (st.lim == lsd_pkg::LIM_NONE ||
        (at_hi && st.lim != lsd_pkg::LIM_HI) ||
        (at_lo && st.lim != lsd_pkg::LIM_LO)) begin
      rise = 18'h00000;
    end else begin
      rise = 18'(i_sample.process_value) - 18'(st.ref_pv);
    end
    // R02 change against main
    small_up = rise < $signed({2'h0, st.main_set});
    small_dn = -rise < $signed({2'h0, st.main_set});
    // R04 heat polarity, R05 cool polarity
    if (!st.reverse) begin
      stall = at_hi ? small_up : small_dn;
    end else begin
      stall = at_hi ? small_dn : small_up;
    end
  end

  // Read mux over the register map.
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (i_s_axi_araddr)
      `LSD_OFF_CTRL: begin
        rd_word[`LSD_CTRL_TYPE_MSB:0] = st.op_type;
        rd_word[`LSD_CTRL_REV_BIT] = st.reverse;
      end
      `LSD_OFF_MAIN: rd_word[15:0] = st.main_set;
      `LSD_OFF_SUB: rd_word[15:0] = st.sub_set;
      `LSD_OFF_ONDLY: rd_word[15:0] = st.on_dly;
      `LSD_OFF_OFFDLY: rd_word[15:0] = st.off_dly;
      `LSD_OFF_STAT: begin
        rd_word[0] = st.event_on;
        rd_word[1] = st.boot_done;
        rd_word[4:2] = st.lim;
        rd_word[31:16] = st.tmr;
      end
      `LSD_OFF_IRQSTS: rd_word[1:0] = st.irq_sts;
      `LSD_OFF_IRQMSK: rd_word[1:0] = st.irq_msk;
      default: rd_hit = 1'b0;
    endcase
  end

  // Writable addresses.
  always_comb begin
    case (st.aw_addr)
      `LSD_OFF_CTRL, `LSD_OFF_MAIN, `LSD_OFF_SUB, `LSD_OFF_ONDLY,
      `LSD_OFF_OFFDLY, `LSD_OFF_IRQMSK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Next state: divider, diagnosis, bus slave and interrupt.
  always_comb begin
    logic [1:0] ev_set;
    ev_set = 2'h0;
    next_st = st;
    next_st.tick = 1'b0;

    // Sampling tick from the divider; the loop is judged only here.
    if (st.div_cnt == 22'(SAMPLE_CYCLES - 1)) begin
      next_st.div_cnt = 22'h000000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 22'h000001;
    end

    // R09 per-tick evaluation
    if (st.tick) begin
      // R07 power-on hold
      next_st.boot_cnt = sat_inc(st.boot_cnt);
      next_st.boot_done = reached(st.boot_cnt, st.off_dly);
      // R02 reference capture
      if (at_hi) begin
        next_st.lim = lsd_pkg::LIM_HI;
        if (st.lim != lsd_pkg::LIM_HI) begin
          next_st.ref_pv = i_sample.process_value;
        end
      end else if (at_lo) begin
        next_st.lim = lsd_pkg::LIM_LO;
        if (st.lim != lsd_pkg::LIM_LO) begin
          next_st.ref_pv = i_sample.process_value;
        end
      end else begin
        next_st.lim = lsd_pkg::LIM_NONE;
      end
      // R08 timer start condition
      if ((at_hi || at_lo) && dev_ok && next_st.lim == st.lim) begin
        next_st.tmr = sat_inc(st.tmr);
      end else begin
        // R09 restart off limit
        next_st.tmr = 16'h0000;
      end
      // R01 type gate, R03 diagnosis time, R06 deviation override
      next_st.event_on = (st.op_type == `LSD_TYPE_STALL) &&
                         next_st.boot_done && dev_ok &&
                         (at_hi || at_lo) && stall &&
                         reached(next_st.tmr, st.on_dly);
    end
    ev_set[`LSD_IRQ_RISE] = next_st.event_on && !st.event_on;
    ev_set[`LSD_IRQ_FALL] = !next_st.event_on && st.event_on;

    // Write address and data are taken in either order.
    if (i_s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_s_axi_wdata;
      next_st.wstrb = i_s_axi_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
      case (st.aw_addr)
        `LSD_OFF_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.op_type = st.wdata[`LSD_CTRL_TYPE_MSB:0];
          end
          if (st.wstrb[1]) begin
            next_st.reverse = st.wdata[`LSD_CTRL_REV_BIT];
          end
        end
        `LSD_OFF_MAIN:
          next_st.main_set = merge16(st.main_set, st.wdata, st.wstrb);
        `LSD_OFF_SUB:
          next_st.sub_set = merge16(st.sub_set, st.wdata, st.wstrb);
        `LSD_OFF_ONDLY:
          next_st.on_dly = merge16(st.on_dly, st.wdata, st.wstrb);
        `LSD_OFF_OFFDLY:
          next_st.off_dly = merge16(st.off_dly, st.wdata, st.wstrb);
        `LSD_OFF_IRQMSK: begin
          if (st.wstrb[0]) begin
            next_st.irq_msk = st.wdata[1:0];
          end
        end
        default: next_st.bresp = `LSD_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // One read at a time; a read of the interrupt status clears it.
    if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
      if (i_s_axi_araddr == `LSD_OFF_IRQSTS) begin
        next_st.irq_sts = 2'h0;
      end
    end
    // A new event wins over a clear in the same cycle.
    next_st.irq_sts = next_st.irq_sts | ev_set;
    next_st.irq = |(next_st.irq_sts & next_st.irq_msk);

    // Ready flags follow the channel occupancy.
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // State register; reset sets every field to a constant.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.lim <= lsd_pkg::LIM_NONE;
      st.main_set <= `LSD_RST_MAIN;
      st.sub_set <= `LSD_RST_SUB;
      st.on_dly <= `LSD_RST_ONDLY;
      st.off_dly <= `LSD_RST_OFFDLY;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flip-flops.
  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready = st.wready;
  assign o_s_axi_bvalid = st.bvalid;
  assign o_s_axi_bresp = st.bresp;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rvalid = st.rvalid;
  assign o_s_axi_rdata = st.rdata;
  assign o_s_axi_rresp = st.rresp;
  assign o_event = st.event_on;
  assign o_irq = st.irq;

  // Checks on the diagnosis.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_type_gate_on: assert property ( // R01
    st.tick && st.op_type != `LSD_TYPE_STALL |=> !o_event
  ) else $error("event set with another operation type");

  a_ref_capture: assert property ( // R02
    st.tick && at_hi && st.lim != lsd_pkg::LIM_HI
      |=> st.ref_pv == $past(i_sample.process_value)
  ) else $error("reference not captured on reaching limit");

  a_diag_time_done: assert property ( // R03
    $rose(o_event) |-> st.tmr >= st.on_dly
  ) else $error("event before diagnosis time");

  a_heat_stall: assert property ( // R04
    $rose(o_event) && !st.reverse && st.lim == lsd_pkg::LIM_HI
      |-> $past(small_up)
  ) else $error("heat event without small rise");

  a_cool_stall: assert property ( // R05
    $rose(o_event) && st.reverse && st.lim == lsd_pkg::LIM_HI
      |-> $past(small_dn)
  ) else $error("cool event without small fall");

  a_dev_force_off: assert property ( // R06
    st.tick && !dev_ok |=> !o_event
  ) else $error("event on with small deviation");

  a_boot_hold_off: assert property ( // R07
    !st.boot_done |-> !o_event
  ) else $error("event during power-on hold");

  a_timer_hold: assert property ( // R08
    st.tick && !dev_ok |=> st.tmr == 16'h0000
  ) else $error("timer ran without hold condition");

  a_tick_only: assert property ( // R09
    !st.tick |=> $stable(o_event) ##1 1'b1
  ) else $error("event changed outside a sampling tick");

  a_irq_level: assert property (
    (st.irq_sts & st.irq_msk) != 2'h0 |-> o_irq
  ) else $error("interrupt low with unmasked status");

endmodule

//--- verification/loop_stall_diag_tb_top.sv
// Self-checking bench for the loop stall diagnosis event block.
// Assumes the package and map header are compiled ahead of this file.
`timescale 1ns/1ps
`include "lsd_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  err_count++; $display("ERROR %0t got %0h exp %0h", $time, got, exp); \
  end end

module loop_stall_diag_tb_top;
  // A short sampling period keeps the whole run to about two thousand cycles.
  localparam int SC = 8;
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;
  // One noted response: the value and the bits that matter.
  typedef struct {logic [33:0] val; logic [33:0] msk;} note_s;
  // One stall case: type, polarity, output, change, deviation, event.
  typedef struct {
    logic [4:0] typ; logic rev; logic [15:0] mv; int dpv; int spd; logic ev;
  } case_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  lsd_pkg::loop_sample_s smp;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, o_rdata;
  logic [3:0] wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_event, o_irq;
  logic [1:0] o_bresp, o_rresp;
  note_s exp_q[$];
  int err_count = 0;
  int n_tests = 0;
  logic pin_req = 1'b0; // Asks the monitor for one compare of the pins.
  // Heat rows first, then cool, then boundaries of limit, band and type.
  case_s cases [12] = '{
    '{5'h16, 1'b0, 16'h03E8, 10, -200, 1'b0},
    '{5'h16, 1'b0, 16'h03E8, 9, -200, 1'b1},
    '{5'h16, 1'b0, 16'h0000, -20, -200, 1'b0},
    '{5'h16, 1'b0, 16'h0000, -5, -200, 1'b1},
    '{5'h16, 1'b1, 16'h03E8, -20, -200, 1'b0},
    '{5'h16, 1'b1, 16'h03E8, 5, -200, 1'b1},
    '{5'h16, 1'b1, 16'h0000, 20, -200, 1'b0},
    '{5'h16, 1'b1, 16'h0000, -5, -200, 1'b1},
    '{5'h16, 1'b0, 16'h03E7, 0, -200, 1'b0},
    '{5'h16, 1'b0, 16'h03E8, 0, 3, 1'b0},
    '{5'h16, 1'b0, 16'h03E8, 0, 5, 1'b1},
    '{5'h15, 1'b0, 16'h03E8, 0, -200, 1'b0}
  };

  loop_stall_diag #(.SAMPLE_CYCLES(SC)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_sample(smp),
    .i_s_axi_awvalid(awvalid), .i_s_axi_awaddr(awaddr),
    .o_s_axi_awready(o_awready), .i_s_axi_wvalid(wvalid),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .o_s_axi_wready(o_wready),
    .o_s_axi_bvalid(o_bvalid), .o_s_axi_bresp(o_bresp),
    .i_s_axi_bready(bready), .i_s_axi_arvalid(arvalid),
    .i_s_axi_araddr(araddr), .o_s_axi_arready(o_arready),
    .o_s_axi_rvalid(o_rvalid), .o_s_axi_rdata(o_rdata),
    .o_s_axi_rresp(o_rresp), .i_s_axi_rready(rready),
    .o_event(o_event), .o_irq(o_irq)
  );

  // The clock toggles every half period of 25 ns.
  always #12.5 sys_clk = ~sys_clk;

  // Each response handshake takes the oldest note off the queue.
  always @(posedge sys_clk) begin
    note_s n;
    logic [33:0] got;
    if ((o_bvalid && bready) || (o_rvalid && rready)) begin
      // A response nobody asked for counts as a mismatch.
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        n = exp_q.pop_front();
        got = o_bvalid ? {o_bresp, 32'h0000_0000} : {o_rresp, o_rdata};
        `CHK(got & n.msk, n.val & n.msk)
      end
    end else if (pin_req) begin
      // Pin notes hold the interrupt and event levels in the low bits.
      n = exp_q.pop_front();
      got = {32'h0000_0000, o_irq, o_event};
      `CHK(got & n.msk, n.val & n.msk)
    end
  end

  // Note the expected interrupt and event levels, then ask for a compare.
  task automatic pins(input logic irq, input logic ev);
    exp_q.push_back('{val: {32'h0000_0000, irq, ev}, msk: 34'h0_0000_0003});
    pin_req <= 1'b1;
    @(posedge sys_clk);
    pin_req <= 1'b0;
  endtask

  // Write one word; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_p = 1'b1;
    logic w_p = 1'b1;
    exp_q.push_back('{val: {r, 32'h0000_0000}, msk: {2'h3, 32'h0000_0000}});
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (o_bvalid) break;
      if (aw_p && o_awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && o_wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  // Read one word and note the expected data under a mask.
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back('{val: {r, d}, msk: {2'h3, m}});
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (o_rvalid) break;
      if (o_arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Status holds event, boot done and the one-hot limit.
  task automatic st(input logic boot, input logic ev, input logic [2:0] lim);
    rd(`LSD_OFF_STAT, {27'h0, lim, boot, ev}, 32'h0000_001F, `LSD_RESP_OKAY);
    // The mask stays clear here, so the interrupt pin must be low.
    pins(1'b0, ev);
  endtask

  task automatic tk(input int n);
    repeat (n * SC) @(posedge sys_clk);
  endtask

  // Leave the limit, return to it, then move the process value.
  task automatic run(input case_s c);
    int base;
    base = 100 + $urandom_range(800);
    wr(`LSD_OFF_CTRL, {23'h0, c.rev, 3'h0, c.typ}, `LSD_RESP_OKAY);
    @(posedge sys_clk);
    smp <= '{process_value: 16'(base), setpoint_value: 16'(base + c.spd),
             manipulated_output: 16'h01F4};
    tk(3);
    st(1'b1, 1'b0, 3'b001);
    @(posedge sys_clk);
    smp.manipulated_output <= c.mv;
    tk(2);
    @(posedge sys_clk);
    smp.process_value <= 16'(base + c.dpv);
    tk(6);
    st(1'b1, c.ev, c.mv == `LSD_MV_HI ? 3'b010 :
       c.mv == `LSD_MV_LO ? 3'b100 : 3'b001);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    if (exp_q.size() != 0) err_count++;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The whole sequence needs about 1900 cycles, so this is generous.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end

  initial begin
    smp = '{process_value: 16'h0100, setpoint_value: 16'h0000,
            manipulated_output: 16'h01F4};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    void'($urandom(32'hB26B730F));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, then refused places.
    rd(`LSD_OFF_CTRL, 32'h0000_0000, FULL, `LSD_RESP_OKAY);
    rd(`LSD_OFF_MAIN, {16'h0, `LSD_RST_MAIN}, FULL, `LSD_RESP_OKAY);
    rd(`LSD_OFF_SUB, {16'h0, `LSD_RST_SUB}, FULL, `LSD_RESP_OKAY);
    rd(`LSD_OFF_ONDLY, {16'h0, `LSD_RST_ONDLY}, FULL, `LSD_RESP_OKAY);
    rd(`LSD_OFF_OFFDLY, {16'h0, `LSD_RST_OFFDLY}, FULL, `LSD_RESP_OKAY);
    rd(8'h20, 32'h0000_0000, FULL, `LSD_RESP_SLVERR);
    wr(`LSD_OFF_STAT, 32'h0000_0001, `LSD_RESP_SLVERR);
    wr(8'h24, 32'h0000_0001, `LSD_RESP_SLVERR);
    wr(`LSD_OFF_ONDLY, 32'h0000_0002, `LSD_RESP_OKAY);
    wr(`LSD_OFF_CTRL, {27'h0, `LSD_TYPE_STALL}, `LSD_RESP_OKAY);
    @(posedge sys_clk);
    smp.manipulated_output <= `LSD_MV_HI;
    // A stall that is held off until the boot period has run out.
    tk(10);
    st(1'b0, 1'b0, 3'b010);
    tk(45);
    st(1'b1, 1'b1, 3'b010);
    foreach (cases[i]) run(cases[i]);
    // A longer diagnosis time must delay the event.
    wr(`LSD_OFF_ONDLY, 32'h0000_0006, `LSD_RESP_OKAY);
    wr(`LSD_OFF_CTRL, {27'h0, `LSD_TYPE_STALL}, `LSD_RESP_OKAY);
    @(posedge sys_clk);
    smp.manipulated_output <= 16'h01F4;
    tk(3);
    @(posedge sys_clk);
    smp.manipulated_output <= `LSD_MV_HI;
    tk(3);
    st(1'b1, 1'b0, 3'b010);
    tk(5);
    st(1'b1, 1'b1, 3'b010);
    // Rise and fall are latched while masked; a read clears them.
    wr(`LSD_OFF_CTRL, 32'h0000_0000, `LSD_RESP_OKAY);
    tk(2);
    pins(1'b0, 1'b0);
    wr(`LSD_OFF_IRQMSK, 32'h0000_0003, `LSD_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    pins(1'b1, 1'b0);
    rd(`LSD_OFF_IRQMSK, 32'h0000_0003, FULL, `LSD_RESP_OKAY);
    rd(`LSD_OFF_IRQSTS, 32'h0000_0003, 32'h0000_0003, `LSD_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    pins(1'b0, 1'b0);
    rd(`LSD_OFF_IRQSTS, 32'h0000_0000, 32'h0000_0003, `LSD_RESP_OKAY);
    repeat (5) @(posedge sys_clk);
    stop_test();
  end
endmodule
